// file: src/gpio_port_pkg.sv
// package: register map, field layout and reset values of the port block
package gpio_port_pkg;

  // ********************************************************************
  // register indices, byte_addr makes the byte address four times each (printed offsets are not all multiples of 4)
  // ********************************************************************
  localparam logic [7:0]  IDX_PORT_A_DATA      = 8'h00;
  localparam logic [7:0]  IDX_PORT_A_DIRECTION = 8'h04;
  localparam logic [7:0]  IDX_PORT_B_DIRECTION = 8'h05;
  localparam logic [7:0]  IDX_PORT_C_DIRECTION = 8'h06;
  localparam logic [7:0]  IDX_PORT_D_DIRECTION = 8'h07;
  localparam logic [7:0]  IDX_PORT_E_DIRECTION = 8'h09;
  localparam logic [7:0]  IDX_KBD_ENABLE       = 8'h17;
  localparam logic [7:0]  IDX_TIMER_CH0_SELECT = 8'h10;
  localparam logic [7:0]  IDX_LED_DRIVE        = 8'h1a;
  localparam logic [7:0]  IDX_RESISTOR_OPTIONS = 8'h1b;
  localparam logic [7:0]  IDX_PORT_B_PULLUPS   = 8'h3e;

  // ********************************************************************
  // implemented bit masks and reset values
  // ********************************************************************
  localparam logic [7:0]  MASK_FULL            = 8'hff;
  localparam logic [7:0]  MASK_PORT_C_DIR      = 8'h0f;
  localparam logic [7:0]  MASK_PORT_E_DIR      = 8'hfc;
  localparam logic [7:0]  MASK_RESISTOR_OPT    = 8'h3f;
  localparam logic [7:0]  MASK_CH0_SELECT      = 8'h03;
  localparam logic [7:0]  RESET_BYTE           = 8'h00;
  localparam logic [31:0] UNMAPPED_READ        = 32'h0000_0000;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic [7:0] port_d_direction;
    logic [7:0] port_e_direction;
    logic [7:0] kbd_enable;
    logic [1:0] channel0_edge_level_select;
    logic [7:0] led_drive_select;
    logic [7:0] pin_resistor_options;
    logic [7:0] port_b_pullup_enables;
  } config_regs_t;

  typedef struct packed {
    config_regs_t cfg;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [7:0]   pa_out_en;
    logic         pc0_gpio_out_en;
  } ctrl_state_t;

  function automatic logic [31:0] byte_addr(input logic [7:0] idx);
    byte_addr = {22'h0, idx, 2'b00};
  endfunction : byte_addr

endpackage : gpio_port_pkg

// file: src/parallel_io_port_control.sv
// parallel port control: direction, port A latches, option registers
//
// Summary of operation
// R1 - software sets every port pin as input or output individually
// R2 - port A is eight bidirectional pins with software-configurable pull-ups
// R3 - keyboard enable bit per port A pin makes it an interrupt input
// R4 - port A holds eight read/write data latches
// R5 - reset leaves the port A data latches untouched
// R6 - port A pin direction follows same-position direction bit
// R7 - port B direction at 0005, eight RW bits, reset zero
// R8 - port C direction at 0006, bits 3..0 only, upper read zero
// R9 - port D direction at 0007, eight RW bits, reset zero
// R10 - port E direction at 0009, bits 7..2 only, reset zero
// R11 - channel 0 edge/level select gives port C pin 0 to timer or gpio
// R12 - direction one enables the output buffer, zero makes an input
// R13 - data read gives latch for outputs, pin for inputs; writes hit latch
`timescale 1ns/1ps
module parallel_io_port_control
  import gpio_port_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PORT_A_PIN_IN,
  output logic      [7:0]  PORT_A_PIN_OUT,
  output logic      [7:0]  PORT_A_PIN_OE_N,
  output logic      [7:0]  PORT_A_PULLUP_EN,
  output logic      [7:0]  PORT_A_KBD_SELECT,
  output logic      [7:0]  PORT_B_DIRECTION,
  output logic      [3:0]  PORT_C_DIRECTION,
  output logic             PORT_C0_TIMER_OWNS,
  output logic      [7:0]  PORT_D_DIRECTION,
  output logic      [7:0]  PORT_E_DIRECTION,
  output logic      [7:0]  LED_DRIVE_SELECT,
  output logic      [7:0]  PIN_RESISTOR_OPTIONS,
  output logic      [7:0]  PORT_B_PULLUP_ENABLES
);

  // ******************************************************************
  // state
  // ******************************************************************
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [7:0]  port_a_data_latches;
  logic [7:0]  next_port_a_data_latches;
  logic        setup;
  logic        wr;
  logic [7:0]  wbyte;
  logic [31:0] rd_value;
  logic        mapped;

  // pin-level read: latch where driven, pin where input
  function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    mix_read = (dir & latch) | (~dir & pin);
  endfunction : mix_read

  // ******************************************************************
  // bus decode
  // ******************************************************************
  always_comb begin
    setup = PSEL && !PENABLE;
    wr    = setup && PWRITE;
    wbyte = PWDATA[7:0];
    mapped   = 1'b1;
    rd_value = UNMAPPED_READ;
    case (PADDR)
      byte_addr(IDX_PORT_A_DATA):
        rd_value = {24'h0, mix_read(state.cfg.port_a_direction,
                                    port_a_data_latches,
                                    PORT_A_PIN_IN)}; // R13
      byte_addr(IDX_PORT_A_DIRECTION):
        rd_value = {24'h0, state.cfg.port_a_direction};
      byte_addr(IDX_PORT_B_DIRECTION):
        rd_value = {24'h0, state.cfg.port_b_direction}; // R7
      byte_addr(IDX_PORT_C_DIRECTION):
        rd_value = {24'h0, state.cfg.port_c_direction & MASK_PORT_C_DIR}; // R8
      byte_addr(IDX_PORT_D_DIRECTION):
        rd_value = {24'h0, state.cfg.port_d_direction}; // R9
      byte_addr(IDX_PORT_E_DIRECTION):
        rd_value = {24'h0, state.cfg.port_e_direction & MASK_PORT_E_DIR}; // R10
      byte_addr(IDX_KBD_ENABLE):
        rd_value = {24'h0, state.cfg.kbd_enable};
      byte_addr(IDX_TIMER_CH0_SELECT):
        rd_value = {30'h0, state.cfg.channel0_edge_level_select};
      byte_addr(IDX_LED_DRIVE):
        rd_value = {24'h0, state.cfg.led_drive_select};
      byte_addr(IDX_RESISTOR_OPTIONS):
        rd_value = {24'h0, state.cfg.pin_resistor_options};
      byte_addr(IDX_PORT_B_PULLUPS):
        rd_value = {24'h0, state.cfg.port_b_pullup_enables};
      default:
        mapped = 1'b0;
    endcase
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    next_state = state;
    next_port_a_data_latches = port_a_data_latches;
    // answer every setup in the following cycle; one wait-free access
    next_state.pready  = setup;
    next_state.pslverr = setup && !mapped;
    next_state.prdata  = (setup && !PWRITE) ? rd_value : UNMAPPED_READ;
    if (wr) begin
      case (PADDR)
        byte_addr(IDX_PORT_A_DATA):
          next_port_a_data_latches = wbyte; // R4 R13
        byte_addr(IDX_PORT_A_DIRECTION):
          next_state.cfg.port_a_direction = wbyte; // R1 R6
        byte_addr(IDX_PORT_B_DIRECTION):
          next_state.cfg.port_b_direction = wbyte; // R1 R7
        byte_addr(IDX_PORT_C_DIRECTION):
          next_state.cfg.port_c_direction = wbyte & MASK_PORT_C_DIR; // R8
        byte_addr(IDX_PORT_D_DIRECTION):
          next_state.cfg.port_d_direction = wbyte; // R9
        byte_addr(IDX_PORT_E_DIRECTION):
          next_state.cfg.port_e_direction = wbyte & MASK_PORT_E_DIR; // R10
        byte_addr(IDX_KBD_ENABLE):
          next_state.cfg.kbd_enable = wbyte; // R3
        byte_addr(IDX_TIMER_CH0_SELECT):
          next_state.cfg.channel0_edge_level_select =
            wbyte[1:0] & MASK_CH0_SELECT[1:0]; // R11
        byte_addr(IDX_LED_DRIVE):
          next_state.cfg.led_drive_select = wbyte;
        byte_addr(IDX_RESISTOR_OPTIONS):
          next_state.cfg.pin_resistor_options = wbyte & MASK_RESISTOR_OPT;
        byte_addr(IDX_PORT_B_PULLUPS):
          next_state.cfg.port_b_pullup_enables = wbyte;
        default: ;
      endcase
    end
    // pin drivers use the committed direction so they move with the write
    next_state.pa_out_en = next_state.cfg.port_a_direction; // R6 R12
    next_state.pc0_gpio_out_en =
      (next_state.cfg.channel0_edge_level_select == 2'b00) &&
      next_state.cfg.port_c_direction[0]; // R11
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= '0; // R7 R8 R9 R10
    end else begin
      state <= next_state;
    end
  end

  // no reset branch: the latches keep their value through reset
  always_ff @(posedge CORE_CLK) begin
    port_a_data_latches <= next_port_a_data_latches; // R5
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  always_comb begin
    PRDATA  = state.prdata;
    PREADY  = state.pready;
    PSLVERR = state.pslverr;
    PORT_A_PIN_OUT   = port_a_data_latches; // R4
    PORT_A_PIN_OE_N  = ~state.pa_out_en; // R12
    // keyboard enable also switches on the pin's pull-up
    PORT_A_PULLUP_EN  = state.cfg.kbd_enable; // R2
    PORT_A_KBD_SELECT = state.cfg.kbd_enable; // R3
    PORT_B_DIRECTION  = state.cfg.port_b_direction;
    PORT_C_DIRECTION  = {state.cfg.port_c_direction[3:1],
                         state.pc0_gpio_out_en};
    PORT_C0_TIMER_OWNS = |state.cfg.channel0_edge_level_select; // R11
    PORT_D_DIRECTION  = state.cfg.port_d_direction;
    PORT_E_DIRECTION  = state.cfg.port_e_direction;
    LED_DRIVE_SELECT      = state.cfg.led_drive_select;
    PIN_RESISTOR_OPTIONS  = state.cfg.pin_resistor_options;
    PORT_B_PULLUP_ENABLES = state.cfg.port_b_pullup_enables;
  end

endmodule : parallel_io_port_control

// file: dv/parallel_io_port_control_monitor.sv
// checker: bus answer and pin relations of the port block
`timescale 1ns/1ps
module pio_monitor (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic [7:0]  PORT_A_PIN_IN,
  input wire logic [7:0]  PORT_A_PIN_OUT,
  input wire logic [7:0]  PORT_A_PIN_OE_N,
  input wire logic [7:0]  PORT_B_DIRECTION,
  input wire logic [3:0]  PORT_C_DIRECTION,
  input wire logic        PORT_C0_TIMER_OWNS,
  input wire logic [7:0]  PORT_E_DIRECTION
);
  logic st;
  logic w;
  assign st = PSEL && !PENABLE;
  assign w = st && PWRITE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  property p_ready; st |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_dir_a; w && PADDR == 32'h10 |=>
    PORT_A_PIN_OE_N == ~$past(PWDATA[7:0]); endproperty
  a_dir_a: assert property (p_dir_a) else $error("oe");
  property p_dir_b; w && PADDR == 32'h14 |=>
    PORT_B_DIRECTION == $past(PWDATA[7:0]); endproperty
  a_dir_b: assert property (p_dir_b) else $error("b dir");
  property p_dir_c; w && PADDR == 32'h18 |=>
    PORT_C_DIRECTION[3:1] == $past(PWDATA[3:1]); endproperty
  a_dir_c: assert property (p_dir_c) else $error("c dir");
  property p_dir_e; w && PADDR == 32'h24 |=>
    PORT_E_DIRECTION == ($past(PWDATA[7:0]) & 8'hfc); endproperty
  a_dir_e: assert property (p_dir_e) else $error("e dir");
  property p_latch; w && PADDR == 32'h00 |=>
    PORT_A_PIN_OUT == $past(PWDATA[7:0]); endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_rd_a; st && !PWRITE && PADDR == 32'h00 |=> PRDATA[7:0] ==
    (~$past(PORT_A_PIN_OE_N) & $past(PORT_A_PIN_OUT)
    | $past(PORT_A_PIN_OE_N) & $past(PORT_A_PIN_IN)); endproperty
  a_rd_a: assert property (p_rd_a) else $error("a read");
  property p_timer; PORT_C0_TIMER_OWNS |-> !PORT_C_DIRECTION[0]; endproperty
  a_timer: assert property (p_timer) else $error("c0 owner");
endmodule : pio_monitor

bind parallel_io_port_control pio_monitor pio_monitor_inst (.CORE_CLK,
  .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .PORT_A_PIN_IN, .PORT_A_PIN_OUT, .PORT_A_PIN_OE_N, .PORT_B_DIRECTION,
  .PORT_C_DIRECTION, .PORT_C0_TIMER_OWNS, .PORT_E_DIRECTION);

// file: dv/pin_board.sv
// pin model: board wiring around port A
`timescale 1ns/1ps
module pin_board (
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  // an undriven pin shows the bench's changing pattern ORed with its pull-up enable, never a stale level
  assign pin_in = ~oe_n & pin_out | oe_n & (pullup_en | ext);
endmodule : pin_board

// file: dv/parallel_io_port_control_bench.sv
// bench: register map, port A data path, reset and timer sharing
`timescale 1ns/1ps
module parallel_io_port_control_bench;
  import gpio_port_pkg::*;
  logic CORE_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PREADY, PSLVERR, PORT_C0_TIMER_OWNS, err;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA;
  logic [7:0] PORT_A_PIN_IN, PORT_A_PIN_OUT, PORT_A_PIN_OE_N, PORT_A_PULLUP_EN;
  logic [7:0] PORT_A_KBD_SELECT, PORT_B_DIRECTION, PORT_D_DIRECTION;
  logic [7:0] PORT_E_DIRECTION, LED_DRIVE_SELECT, PIN_RESISTOR_OPTIONS;
  logic [7:0] PORT_B_PULLUP_ENABLES, ext = 8'h00, q, d, lat, dir;
  logic [3:0] PORT_C_DIRECTION;
  int n_mismatch = 0, comparisons = 0;
  localparam logic [7:0] idx_tab [8] = '{IDX_PORT_B_DIRECTION,
    IDX_PORT_C_DIRECTION, IDX_PORT_D_DIRECTION, IDX_PORT_E_DIRECTION,
    IDX_LED_DRIVE, IDX_RESISTOR_OPTIONS, IDX_PORT_B_PULLUPS, IDX_KBD_ENABLE};
  localparam logic [7:0] msk_tab [8] = '{MASK_FULL, MASK_PORT_C_DIR,
    MASK_FULL, MASK_PORT_E_DIR, MASK_FULL, MASK_RESISTOR_OPT, MASK_FULL,
    MASK_FULL};
  always #2 CORE_CLK = ~CORE_CLK;
  parallel_io_port_control parallel_io_port_control_inst (.CORE_CLK,
    .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .PORT_A_PIN_IN, .PORT_A_PIN_OUT, .PORT_A_PIN_OE_N,
    .PORT_A_PULLUP_EN, .PORT_A_KBD_SELECT, .PORT_B_DIRECTION,
    .PORT_C_DIRECTION, .PORT_C0_TIMER_OWNS, .PORT_D_DIRECTION,
    .PORT_E_DIRECTION, .LED_DRIVE_SELECT, .PIN_RESISTOR_OPTIONS,
    .PORT_B_PULLUP_ENABLES);
  pin_board pin_board_inst (.oe_n(PORT_A_PIN_OE_N), .pin_out(PORT_A_PIN_OUT),
    .pullup_en(PORT_A_PULLUP_EN), .ext(ext), .pin_in(PORT_A_PIN_IN));
  function automatic logic [7:0] a_read(logic [7:0] l, dr, p);
    return dr & l | ~dr & p;
  endfunction : a_read
  task automatic xfer(input logic wr, input logic [7:0] idx, dat);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    {PSEL, PENABLE, PWRITE} <= {2'b10, wr};
    PADDR <= {22'h0, idx, 2'b00};
    PWDATA <= {24'h0, dat};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    q = PRDATA[7:0];
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask : xfer
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h1bea));
    repeat (3) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    foreach (idx_tab[i]) begin
      xfer(1'b0, idx_tab[i], 8'h00);
      chk(q, 8'h00);
      d = $urandom;
      xfer(1'b1, idx_tab[i], d);
      xfer(1'b0, idx_tab[i], 8'h00);
      chk(q, d & msk_tab[i]);
    end
    xfer(1'b1, 8'h3f, 8'hff);
    xfer(1'b0, 8'h3f, 8'h00);
    chk({q[6:0], err}, 8'h01);
    xfer(1'b1, IDX_PORT_D_DIRECTION, 8'h5a);
    chk(PORT_D_DIRECTION, 8'h5a);
    xfer(1'b1, IDX_LED_DRIVE, 8'ha5);
    chk(LED_DRIVE_SELECT, 8'ha5);
    xfer(1'b1, IDX_RESISTOR_OPTIONS, 8'hff);
    chk(PIN_RESISTOR_OPTIONS, MASK_RESISTOR_OPT);
    xfer(1'b1, IDX_PORT_B_PULLUPS, 8'h3c);
    chk(PORT_B_PULLUP_ENABLES, 8'h3c);
    xfer(1'b1, IDX_PORT_E_DIRECTION, 8'hff);
    chk(PORT_E_DIRECTION, MASK_PORT_E_DIR);
    $display("test registers done");
    xfer(1'b1, IDX_PORT_C_DIRECTION, 8'h0f);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, IDX_TIMER_CH0_SELECT, 8'(s));
      chk({7'h0, PORT_C0_TIMER_OWNS}, {7'h0, s != 0});
      chk({4'h0, PORT_C_DIRECTION}, {5'h07, s == 0});
    end
    $display("test timer sharing done");
    xfer(1'b1, IDX_KBD_ENABLE, 8'hf0);
    chk(PORT_A_KBD_SELECT, 8'hf0);
    chk(PORT_A_PULLUP_EN, 8'hf0);
    repeat (8) begin
      lat = $urandom;
      dir = $urandom;
      ext <= $urandom;
      xfer(1'b1, IDX_PORT_A_DATA, lat);
      xfer(1'b1, IDX_PORT_A_DIRECTION, dir);
      xfer(1'b0, IDX_PORT_A_DATA, 8'h00);
      chk(q, a_read(lat, dir, ext | 8'hf0));
      chk(PORT_A_PIN_OE_N, ~dir);
      chk(PORT_A_PIN_OUT, lat);
    end
    $display("test port a done");
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    chk(PORT_A_PIN_OUT, lat);
    chk(PORT_A_PIN_OE_N, 8'hff);
    RESET_N <= 1'b1;
    xfer(1'b0, IDX_PORT_A_DATA, 8'h00);
    chk(q, ext);
    chk(PORT_B_DIRECTION, 8'h00);
    $display("test reset done");
    report_and_stop();
  end
endmodule : parallel_io_port_control_bench
